// *** logic/display_reset_params.svh ***
// timing constants, otp map and reset values for the display reset sequencer
`ifndef DISPLAY_RESET_PARAMS_SVH
`define DISPLAY_RESET_PARAMS_SVH

// ----------------------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------------------
`define RST_CLK_MHZ        125
`define T_REJECT_US        5
`define T_ACCEPT_US        10
`define T_RELOAD_MS        5
`define T_SLEEP_EXIT_MS    120
`define T_BLANK_MAX_MS     120

// least time, exact at 125 MHz
`define RST_REJECT_CYC     (`T_REJECT_US * `RST_CLK_MHZ)
// longest time, exact at 125 MHz
`define RST_ACCEPT_CYC     (`T_ACCEPT_US * `RST_CLK_MHZ)
`define RELOAD_CYC         (`T_RELOAD_MS * `RST_CLK_MHZ * 1000)
`define SLEEP_EXIT_CYC     (`T_SLEEP_EXIT_MS * `RST_CLK_MHZ * 1000)
`define BLANK_MAX_CYC      (`T_BLANK_MAX_MS * `RST_CLK_MHZ * 1000)

`define RST_CNT_W          11
`define SEQ_CNT_W          24

// ----------------------------------------------------------------------------
// otp map and reset values
// ----------------------------------------------------------------------------
`define OTP_ADDR_W         3
`define OTP_ADDR_ID1       3'h0
`define OTP_ADDR_ID2       3'h1
`define OTP_ADDR_ID3       3'h2
`define OTP_ADDR_ID4       3'h3
`define OTP_ADDR_COMMON_VOLTAGE_TRIM      3'h4
`define OTP_ADDR_LAST      3'h4
`define ID_RESET_VAL       8'h00
`define COMMON_VOLTAGE_TRIM_RESET_VAL     8'h00

`endif

// *** logic/display_reset_pkg.sv ***
// types shared by the display reset sequencer
package display_reset_pkg;

   typedef enum logic [2:0]
   {
      ST_RUN  = 3'b001,
      ST_HOLD = 3'b010,
      ST_LOAD = 3'b100
   } seq_state_e;

   typedef logic [7:0] otp_byte_t;

endpackage : display_reset_pkg

// *** logic/reset_filter_if.sv ***
// filtered reset status passed from the pin filter to the sequencer
`timescale 1ns/1ps

interface reset_filter_if;
   logic reset_hold;
   logic reset_release;

   modport filt (output reset_hold, output reset_release);
   modport seq  (input reset_hold, input reset_release);
endinterface : reset_filter_if

// *** logic/reset_pulse_filter.sv ***
// spike filter on the hardware reset pin
`timescale 1ns/1ps
`include "display_reset_params.svh"

module reset_pulse_filter
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         hw_reset_in_n,
   reset_filter_if.filt      rst
);

   localparam logic [`RST_CNT_W-1:0] ACC_LAST = `RST_CNT_W'(`RST_ACCEPT_CYC - 1);
   localparam logic [`RST_CNT_W-1:0] REJ_LAST = `RST_CNT_W'(`RST_REJECT_CYC - 1);

   logic [`RST_CNT_W-1:0] low_cnt;
   logic [`RST_CNT_W-1:0] high_cnt;
   logic                  high_stable;

   assign high_stable = hw_reset_in_n && (high_cnt == REJ_LAST);

   // ----------------------------------------------------------------------------
   // low and high time counters
   // ----------------------------------------------------------------------------
   // a high blip shorter than the reject time only pauses the low count
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         low_cnt <= '0;
      else if (!hw_reset_in_n && low_cnt != ACC_LAST)
         low_cnt <= low_cnt + 1'b1;
      else if (high_stable)
         low_cnt <= '0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         high_cnt <= '0;
      else if (!hw_reset_in_n)
         high_cnt <= '0;
      else if (high_cnt != REJ_LAST)
         high_cnt <= high_cnt + 1'b1;
   end

   // ----------------------------------------------------------------------------
   // accepted reset
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rst.reset_hold <= 1'b0;
      else if (!hw_reset_in_n && low_cnt == ACC_LAST)
         rst.reset_hold <= 1'b1;
      else if (high_stable)
         rst.reset_hold <= 1'b0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rst.reset_release <= 1'b0;
      else
         rst.reset_release <= rst.reset_hold && high_stable;
   end

   property p_accept_time;
      @(posedge clk) disable iff (!nrst)
      $rose(rst.reset_hold) |-> $past(low_cnt) == ACC_LAST && !$past(hw_reset_in_n);
   endproperty
   a_accept_time: assert property (p_accept_time)
      else $error("reset accepted before the low time reached the threshold");

   property p_glitch_kept;
      @(posedge clk) disable iff (!nrst)
      rst.reset_hold && hw_reset_in_n && high_cnt != REJ_LAST |=> rst.reset_hold;
   endproperty
   a_glitch_kept: assert property (p_glitch_kept)
      else $error("short high glitch ended an accepted reset");

   property p_short_low_ignored;
      @(posedge clk) disable iff (!nrst)
      !rst.reset_hold && low_cnt < ACC_LAST |=> !rst.reset_hold;
   endproperty
   a_short_low_ignored: assert property (p_short_low_ignored)
      else $error("reset asserted while low time below threshold");

endmodule : reset_pulse_filter

// *** logic/display_reset_sequencer.sv ***
// hardware reset sequencer: pin filter, blanking, otp reload and command gating
//
// Behaviour
// - lows under 5 us ignored, over 10 reset
// - spike rejection stays active during a reset
// - blank display; awake blanking ends within 120 ms
// - reset returns all state to defaults
// - reload identity bytes and trim from otp
// - reload every reset, done within 5 ms
`timescale 1ns/1ps
`include "display_reset_params.svh"

module display_reset_sequencer
#(
   parameter int unsigned CYC_RELOAD     = `RELOAD_CYC,
   parameter int unsigned CYC_SLEEP_EXIT = `SLEEP_EXIT_CYC,
   parameter int unsigned CYC_BLANK_MAX  = `BLANK_MAX_CYC
)
(
   input  wire logic                        clk,
   input  wire logic                        nrst,
   input  wire logic                        hw_reset_in_n,
   input  wire logic                        sleep_in,
   input  wire logic                        panel_blank_done,
   input  wire logic                        display_on,
   output logic                             display_blank,
   output logic                             blank_seq_busy,
   output logic                             core_reset_n,
   output logic                             otp_rd_req,
   output logic [`OTP_ADDR_W-1:0]           otp_addr,
   input  wire display_reset_pkg::otp_byte_t otp_rd_data,
   input  wire logic                        otp_rd_valid,
   output display_reset_pkg::otp_byte_t     ident_byte_one,
   output display_reset_pkg::otp_byte_t     ident_byte_two,
   output display_reset_pkg::otp_byte_t     ident_byte_three,
   output display_reset_pkg::otp_byte_t     ident_byte_four,
   output display_reset_pkg::otp_byte_t     common_voltage_trim,
   input  wire logic                        cmd_valid,
   input  wire logic                        cmd_sleep_exit,
   output logic                             cmd_accept,
   output logic                             cmd_drop,
   output logic                             cmd_enable,
   output logic                             sleep_exit_enable
);

   localparam logic [`SEQ_CNT_W-1:0] RELOAD_LAST = `SEQ_CNT_W'(CYC_RELOAD - 1);
   localparam logic [`SEQ_CNT_W-1:0] SLEEP_LAST  = `SEQ_CNT_W'(CYC_SLEEP_EXIT - 1);
   localparam logic [`SEQ_CNT_W-1:0] BLANK_LAST  = `SEQ_CNT_W'(CYC_BLANK_MAX - 1);

   reset_filter_if rst ();

   reset_pulse_filter u_filter
   (
      .clk           (clk),
      .nrst          (nrst),
      .hw_reset_in_n (hw_reset_in_n),
      .rst           (rst)
   );

   display_reset_pkg::seq_state_e state;
   logic [`SEQ_CNT_W-1:0]         since_cnt;
   logic [`SEQ_CNT_W-1:0]         blank_cnt;
   logic                          hold_start;
   logic                          load_take;
   logic                          load_last;
   logic                          reload_timeout;

   assign hold_start     = rst.reset_hold && state != display_reset_pkg::ST_HOLD;
   assign load_take      = state == display_reset_pkg::ST_LOAD && otp_rd_valid;
   assign load_last      = load_take && otp_addr == `OTP_ADDR_LAST;
   assign reload_timeout = state == display_reset_pkg::ST_LOAD && since_cnt == RELOAD_LAST;

   // ----------------------------------------------------------------------------
   // sequence state
   // ----------------------------------------------------------------------------
   // power-on release behaves like a pin release: the reload runs at once
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         state <= display_reset_pkg::ST_LOAD;
      else
      begin
         case (state)
            display_reset_pkg::ST_RUN:
               if (rst.reset_hold)
                  state <= display_reset_pkg::ST_HOLD;
            display_reset_pkg::ST_HOLD:
               if (rst.reset_release)
                  state <= display_reset_pkg::ST_LOAD;
            display_reset_pkg::ST_LOAD:
               if (rst.reset_hold)
                  state <= display_reset_pkg::ST_HOLD;
               else if (load_last || reload_timeout)
                  state <= display_reset_pkg::ST_RUN;
            default:
               state <= display_reset_pkg::ST_HOLD;
         endcase
      end
   end

   // time since the reset pin was released, saturating at the sleep-exit wait
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         since_cnt <= '0;
      else if (rst.reset_hold)
         since_cnt <= '0;
      else if (since_cnt != SLEEP_LAST)
         since_cnt <= since_cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         core_reset_n <= 1'b0;
      else
         core_reset_n <= state == display_reset_pkg::ST_RUN && !rst.reset_hold;
   end

   // ----------------------------------------------------------------------------
   // otp reload
   // ----------------------------------------------------------------------------
   // a read that never answers is cut off by the reload window; unread bytes
   // keep their reset values rather than stalling the whole device
   assign otp_rd_req = state == display_reset_pkg::ST_LOAD && !rst.reset_hold;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         otp_addr <= `OTP_ADDR_ID1;
      else if (state != display_reset_pkg::ST_LOAD)
         otp_addr <= `OTP_ADDR_ID1;
      else if (load_take && !load_last)
         otp_addr <= otp_addr + 1'b1;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ident_byte_one      <= `ID_RESET_VAL;
         ident_byte_two      <= `ID_RESET_VAL;
         ident_byte_three    <= `ID_RESET_VAL;
         ident_byte_four     <= `ID_RESET_VAL;
         common_voltage_trim <= `COMMON_VOLTAGE_TRIM_RESET_VAL;
      end
      else if (rst.reset_hold)
      begin
         ident_byte_one      <= `ID_RESET_VAL;
         ident_byte_two      <= `ID_RESET_VAL;
         ident_byte_three    <= `ID_RESET_VAL;
         ident_byte_four     <= `ID_RESET_VAL;
         common_voltage_trim <= `COMMON_VOLTAGE_TRIM_RESET_VAL;
      end
      else if (load_take)
      begin
         case (otp_addr)
            `OTP_ADDR_ID1:  ident_byte_one      <= otp_rd_data;
            `OTP_ADDR_ID2:  ident_byte_two      <= otp_rd_data;
            `OTP_ADDR_ID3:  ident_byte_three    <= otp_rd_data;
            `OTP_ADDR_ID4:  ident_byte_four     <= otp_rd_data;
            `OTP_ADDR_COMMON_VOLTAGE_TRIM: common_voltage_trim <= otp_rd_data;
            default:        ident_byte_one      <= ident_byte_one;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // blanking
   // ----------------------------------------------------------------------------
   // a sleeping panel is already dark, so no blanking sequence is started
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         blank_seq_busy <= 1'b0;
      else if (hold_start && !sleep_in)
         blank_seq_busy <= 1'b1;
      else if (panel_blank_done || blank_cnt == BLANK_LAST)
         blank_seq_busy <= 1'b0;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         blank_cnt <= '0;
      else if (!blank_seq_busy || hold_start)
         blank_cnt <= '0;
      else
         blank_cnt <= blank_cnt + 1'b1;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         display_blank <= 1'b1;
      else if (rst.reset_hold)
         display_blank <= 1'b1;
      else if (display_on && state == display_reset_pkg::ST_RUN)
         display_blank <= 1'b0;
   end

   // ----------------------------------------------------------------------------
   // command gating
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cmd_enable <= 1'b0;
      else if (rst.reset_hold)
         cmd_enable <= 1'b0;
      else if (since_cnt == RELOAD_LAST)
         cmd_enable <= 1'b1;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sleep_exit_enable <= 1'b0;
      else if (rst.reset_hold)
         sleep_exit_enable <= 1'b0;
      else if (since_cnt == SLEEP_LAST)
         sleep_exit_enable <= 1'b1;
   end

   // early commands are dropped, not queued
   assign cmd_accept = cmd_valid && cmd_enable && core_reset_n
                       && (!cmd_sleep_exit || sleep_exit_enable);
   assign cmd_drop   = cmd_valid && !cmd_accept;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   property p_blank_awake;
      @(posedge clk) disable iff (!nrst)
      hold_start && !sleep_in |=> display_blank && blank_seq_busy;
   endproperty
   a_blank_awake: assert property (p_blank_awake)
      else $error("awake reset did not start blanking");

   property p_blank_bound;
      @(posedge clk) disable iff (!nrst)
      blank_seq_busy |-> blank_cnt <= BLANK_LAST;
   endproperty
   a_blank_bound: assert property (p_blank_bound)
      else $error("blanking ran past its limit");

   property p_defaults_in_reset;
      @(posedge clk) disable iff (!nrst)
      rst.reset_hold |=> !core_reset_n && ident_byte_one == `ID_RESET_VAL
                         && common_voltage_trim == `COMMON_VOLTAGE_TRIM_RESET_VAL && !cmd_enable;
   endproperty
   a_defaults_in_reset: assert property (p_defaults_in_reset)
      else $error("state not at defaults during reset");

   property p_load_trim;
      @(posedge clk) disable iff (!nrst)
      load_take && !rst.reset_hold && otp_addr == `OTP_ADDR_COMMON_VOLTAGE_TRIM
      |=> common_voltage_trim == $past(otp_rd_data);
   endproperty
   a_load_trim: assert property (p_load_trim)
      else $error("trim value not taken from otp");

   property p_reload_after_release;
      @(posedge clk) disable iff (!nrst)
      rst.reset_release |=> state == display_reset_pkg::ST_LOAD && since_cnt == 1;
   endproperty
   a_reload_after_release: assert property (p_reload_after_release)
      else $error("reload did not start at reset release");

   property p_reload_window;
      @(posedge clk) disable iff (!nrst)
      state == display_reset_pkg::ST_LOAD |-> since_cnt <= RELOAD_LAST;
   endproperty
   a_reload_window: assert property (p_reload_window)
      else $error("reload still running after its window");

   property p_no_early_cmd;
      @(posedge clk) disable iff (!nrst)
      cmd_accept |-> since_cnt >= RELOAD_LAST
                     && (!cmd_sleep_exit || since_cnt == SLEEP_LAST);
   endproperty
   a_no_early_cmd: assert property (p_no_early_cmd)
      else $error("command accepted before its wait elapsed");

endmodule : display_reset_sequencer

// *** tb/otp_store_model.sv ***
// otp store model answering the sequencer's reload reads
`timescale 1ns/1ps
`include "display_reset_params.svh"

module otp_store_model
(
   input  wire logic                   clk,
   input  wire logic [1:0]             mode,
   input  wire logic                   otp_rd_req,
   input  wire logic [`OTP_ADDR_W-1:0] otp_addr,
   output display_reset_pkg::otp_byte_t otp_rd_data,
   output logic                        otp_rd_valid
);
   // ---------------------------------------------------------------------
   // answer timing
   // ---------------------------------------------------------------------
   // mode 0 answers at once, 1 after three idle cycles, 2 never answers
   display_reset_pkg::otp_byte_t mem [5];
   logic [1:0]                   wait_cnt;

   initial
   begin
      otp_rd_valid = 1'b0;
      otp_rd_data  = 8'h00;
      wait_cnt     = 2'h0;
   end

   always @(posedge clk)
   begin
      otp_rd_valid <= 1'b0;
      // data toggles between answers so a stale byte is never mistaken for good
      otp_rd_data  <= ~otp_rd_data;
      wait_cnt     <= 2'h0;
      if (otp_rd_req && !otp_rd_valid && mode != 2'h2)
      begin
         if (mode == 2'h0 || wait_cnt == 2'h3)
         begin
            otp_rd_valid <= 1'b1;
            otp_rd_data  <= mem[otp_addr];
         end
         else
            wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule : otp_store_model

// *** tb/display_reset_sequencer_bench.sv ***
// self-checking bench for the display reset sequencer
`timescale 1ns/1ps
`include "display_reset_params.svh"

module display_reset_sequencer_bench;
   localparam int RELOAD = 50;
   localparam int SLEEPX = 200;
   localparam int BLANKM = 100;

   logic                         clk = 1'b0, nrst = 1'b0, hw_reset_in_n = 1'b1;
   logic                         sleep_in = 1'b0, panel_blank_done = 1'b0, display_on = 1'b0;
   logic                         cmd_valid = 1'b0, cmd_sleep_exit = 1'b0;
   logic [1:0]                   mode = 2'h0;
   logic                         display_blank, blank_seq_busy, core_reset_n, otp_rd_req;
   logic                         otp_rd_valid, cmd_accept, cmd_drop, cmd_enable;
   logic                         sleep_exit_enable;
   logic [`OTP_ADDR_W-1:0]       otp_addr;
   display_reset_pkg::otp_byte_t otp_rd_data, id1, id2, id3, id4, trim;
   display_reset_pkg::otp_byte_t otp [5];
   int                           num_errors = 0, tests_run = 0, seed;

   always #4 clk = ~clk;

   display_reset_sequencer #(.CYC_RELOAD(RELOAD), .CYC_SLEEP_EXIT(SLEEPX),
      .CYC_BLANK_MAX(BLANKM)) u_dut
   (
      .clk(clk), .nrst(nrst), .hw_reset_in_n(hw_reset_in_n), .sleep_in(sleep_in),
      .panel_blank_done(panel_blank_done), .display_on(display_on),
      .display_blank(display_blank), .blank_seq_busy(blank_seq_busy),
      .core_reset_n(core_reset_n), .otp_rd_req(otp_rd_req), .otp_addr(otp_addr),
      .otp_rd_data(otp_rd_data), .otp_rd_valid(otp_rd_valid),
      .ident_byte_one(id1), .ident_byte_two(id2), .ident_byte_three(id3),
      .ident_byte_four(id4), .common_voltage_trim(trim), .cmd_valid(cmd_valid),
      .cmd_sleep_exit(cmd_sleep_exit), .cmd_accept(cmd_accept), .cmd_drop(cmd_drop),
      .cmd_enable(cmd_enable), .sleep_exit_enable(sleep_exit_enable)
   );

   otp_store_model u_otp
   (
      .clk(clk), .mode(mode), .otp_rd_req(otp_rd_req), .otp_addr(otp_addr),
      .otp_rd_data(otp_rd_data), .otp_rd_valid(otp_rd_valid)
   );

   // ---------------------------------------------------------------------
   // checking and helpers
   // ---------------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   function automatic logic pick(input int sel);
      case (sel)
         0: return core_reset_n;
         1: return cmd_enable;
         2: return sleep_exit_enable;
         default: return blank_seq_busy;
      endcase
   endfunction : pick

   task automatic wait_for(input int sel, input logic lvl, input int bound);
      int n;
      n = 0;
      while (pick(sel) !== lvl && n < bound)
      begin
         cyc(1);
         n++;
      end
      if (pick(sel) !== lvl)
      begin
         num_errors++;
         $display("MISMATCH wait %0d expected %b seen %b", sel, lvl, pick(sel));
         results();
      end
   endtask : wait_for

   // a silent otp leaves every byte at its reset value
   function automatic display_reset_pkg::otp_byte_t exp_id(input int i, input logic clr);
      return (clr || mode == 2'h2) ? 8'h00 : otp[i];
   endfunction : exp_id

   task automatic chk_ids(input logic clr);
      chk("ident_byte_one", id1, exp_id(0, clr));
      chk("ident_byte_two", id2, exp_id(1, clr));
      chk("ident_byte_three", id3, exp_id(2, clr));
      chk("ident_byte_four", id4, exp_id(3, clr));
      chk("common_voltage_trim", trim, exp_id(4, clr));
   endtask : chk_ids

   task automatic load_otp(input logic [1:0] md);
      mode = md;
      for (int i = 0; i < 5; i++)
      begin
         otp[i] = 8'($random(seed));
         u_otp.mem[i] = otp[i];
      end
   endtask : load_otp

   task automatic send(input logic se, input logic ok);
      cmd_valid = 1'b1;
      cmd_sleep_exit = se;
      #1;
      chk("cmd_accept", cmd_accept, ok);
      chk("cmd_drop", cmd_drop, !ok);
      cyc(1);
      cmd_valid = 1'b0;
      cmd_sleep_exit = 1'b0;
      cyc(1);
   endtask : send

   // ---------------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------------
   // commands are sent early on purpose to see them dropped
   task automatic gates(input logic early);
      if (early)
         send(1'b0, 1'b0);
      send(1'b1, 1'b0);
      wait_for(1, 1'b1, RELOAD);
      send(1'b0, 1'b1);
      send(1'b1, 1'b0);
      wait_for(2, 1'b1, SLEEPX);
      send(1'b1, 1'b1);
      display_on = 1'b1;
      cyc(2);
      chk("display_blank", display_blank, 1'b0);
      display_on = 1'b0;
   endtask : gates

   task automatic spike(input int lo);
      int bad;
      bad = 0;
      hw_reset_in_n = 1'b0;
      for (int i = 0; i < lo + 700; i++)
      begin
         if (i == lo)
            hw_reset_in_n = 1'b1;
         cyc(1);
         if (core_reset_n !== 1'b1)
            bad = 1;
      end
      chk("spike_no_reset", 8'(bad), 8'h00);
      chk("cmd_enable", cmd_enable, 1'b1);
      chk_ids(1'b0);
   endtask : spike

   task automatic hw_reset(input logic slp, input logic done, input logic [1:0] md);
      int lo;
      lo = 1260 + ({$random(seed)} % 40);
      sleep_in = slp;
      hw_reset_in_n = 1'b0;
      cyc(400);
      hw_reset_in_n = 1'b1;
      cyc(3);
      hw_reset_in_n = 1'b0;
      cyc(lo - 400);
      chk("core_reset_n", core_reset_n, 1'b0);
      chk("display_blank", display_blank, 1'b1);
      chk("blank_seq_busy", blank_seq_busy, !slp);
      chk("cmd_enable", cmd_enable, 1'b0);
      chk("sleep_exit_enable", sleep_exit_enable, 1'b0);
      chk_ids(1'b1);
      if (done)
      begin
         panel_blank_done = 1'b1;
         cyc(1);
         panel_blank_done = 1'b0;
         chk("blank_seq_busy", blank_seq_busy, 1'b0);
      end
      else
         wait_for(3, 1'b0, BLANKM);
      // a high blip shorter than the reject time must not end an accepted reset
      hw_reset_in_n = 1'b1;
      cyc(620);
      hw_reset_in_n = 1'b0;
      cyc(2);
      chk("core_reset_n", core_reset_n, 1'b0);
      chk("cmd_enable", cmd_enable, 1'b0);
      load_otp(md);
      hw_reset_in_n = 1'b1;
      wait_for(0, 1'b1, 625 + RELOAD + 4);
      chk_ids(1'b0);
      chk("otp_rd_req", otp_rd_req, 1'b0);
      chk("otp_addr", 8'(otp_addr), 8'h00);
      gates(md != 2'h2);
   endtask : hw_reset

   initial
   begin
      seed = 32'h39f5;
      load_otp(2'h0);
      cyc(12);
      nrst = 1'b1;
      wait_for(0, 1'b1, RELOAD + 4);
      chk_ids(1'b0);
      gates(1'b1);
      spike(624);
      spike(1 + ({$random(seed)} % 600));
      hw_reset(1'b0, 1'b1, 2'h1);
      hw_reset(1'b1, 1'b0, 2'h0);
      hw_reset(1'b0, 1'b0, 2'h2);
      results();
   end
endmodule : display_reset_sequencer_bench
